/* File: core/intc_pkg.sv */
// Purpose: shared constants and types of the prioritized interrupt controller
// Assumes: 16-bit register port with word indices, 24-bit program addresses
// Notes:   source numbers equal natural order; vector number is source plus eight
package intc_pkg;
  localparam int          NUM_SRC        = 45;
  localparam int          NUM_TRAP       = 4;
  localparam int          NUM_EXT        = 5;
  localparam int          NUM_PRIO_REG   = 12;
  localparam logic [47:0] SRC_MASK       = 48'h1dff_ffff_ffff;
  localparam logic [4:0]  OFS_FLAGS      = 5'h00;
  localparam logic [4:0]  OFS_ENABLES    = 5'h03;
  localparam logic [4:0]  OFS_PRIO       = 5'h06;
  localparam logic [4:0]  OFS_GCTL1      = 5'h12;
  localparam logic [4:0]  OFS_GCTL2      = 5'h13;
  localparam logic [4:0]  OFS_CPU_LEVEL  = 5'h14;
  localparam logic [4:0]  OFS_TIMED_LOW_PRIORITY_DISABLE_COUNT = 5'h15;
  localparam int          NEST_DIS_BIT   = 15;
  localparam int          TIMED_LOW_PRIORITY_DISABLE_BIT       = 14;
  localparam int          ALT_TABLE_BIT  = 15;
  localparam int          TRAP_FLAG_LSB  = 1;
  localparam int          TRAP_ADDR      = 1;
  localparam logic [15:0] GCTL1_WMASK    = 16'h801e;
  localparam logic [15:0] GCTL2_WMASK    = 16'h801f;
  localparam logic [15:0] REG_RST        = 16'h0000;
  localparam logic [3:0]  LEVEL_RST      = 4'h0;
  localparam logic [13:0] TIMED_LOW_PRIORITY_DISABLE_RST       = 14'h0000;
  localparam logic [2:0]  TIMED_LOW_PRIORITY_DISABLE_FLOOR     = 3'h6;
  localparam logic [3:0]  TRAP_LEVEL [NUM_TRAP] = '{4'he, 4'hc, 4'hd, 4'hb};
  localparam logic [5:0]  TRAP_VEC   [NUM_TRAP] = '{6'h01, 6'h02, 6'h03, 6'h04};
  localparam logic [5:0]  IRQ_VEC_BASE   = 6'h08;
  localparam logic [5:0]  EXT_SRC    [NUM_EXT]  = '{6'h00, 6'h10, 6'h17, 6'h24, 6'h25};
  localparam logic [23:0] VEC_FIRST      = 24'h000004;
  localparam logic [23:0] VEC_LAST       = 24'h0000fe;
  localparam logic [23:0] ALT_BASE       = 24'h000084;
  localparam int          STACK_DEPTH    = 16;
  localparam logic [4:0]  DEPTH_FULL     = 5'h10;
  typedef enum logic [1:0] {ST_IDLE, ST_OFFER, ST_FETCH} ctl_state_t;
endpackage

/* File: core/prio_intc.sv */
// Purpose: flags, enables, priorities and arbitration of interrupts and traps
// Assumes: core gives one instr_cycle pulse per instruction cycle
// Notes:   registers on a plain port, read data one cycle after the strobe
//
// What this block does
// - Arbitrates 44 interrupt sources and 4 traps by priority toward the core.
// - Request flags set by source events; only a software write clears them.
// - Flags set on every event whatever the enable bit says.
// - A pending request is forwarded only if its own enable bit is set.
// - Each source has priority 1 to 7, seven highest.
// - Priority zero never interrupts, same as a disabled source.
// - Priority field is the low three bits of a nibble; top bit reads zero.
// - CPU priority level is four bits, top bit core control, rest status.
// - Interrupt only when priority is strictly above the CPU level.
// - Flags sampled at each instruction cycle start, evaluated during it.
// - On acceptance old level is saved unless the stack is full, and the accepted level loaded.
// - Traps use levels 11 to 14, so the level top bit is set.
// - Nesting disable blocks any new interrupt while one is serviced.
// - While nesting disable is one, the CPU level ignores software writes.
// - Timed disable blocks levels 6 and below; status bit 14 stays set meanwhile.
// - Equal priority ties go to the lowest natural order number.
// - Natural order number equals the interrupt number.
// - Sources 0 to 44 at vectors from 8; number 41 and 45-53 reserved.
// - The 24-bit vector word from the program bus loads the program counter.
// - 126 vectors at program addresses 0x000004 to 0x0000FE.
// - Instruction fetch from vector space raises an address error trap.
// - A jump into vector space raises an address error trap.
// - Control 1 holds trap flags; control 2 holds pin edges and table select.
`timescale 1ns/1ps
`default_nettype none
module prio_intc
  import intc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic [44:0] src_event,
  input  wire logic [4:0]  ext_pin,
  input  wire logic [3:0]  trap_event,
  input  wire logic        instr_cycle,
  input  wire logic        fetch_valid,
  input  wire logic [23:0] fetch_addr,
  input  wire logic        jump_valid,
  input  wire logic [23:0] jump_target,
  input  wire logic        irq_ack,
  input  wire logic        irq_return,
  input  wire logic        vector_word_valid,
  input  wire logic [23:0] vector_word,
  output logic             irq_req,
  output logic      [3:0]  irq_level,
  output logic      [5:0]  irq_vector_num,
  output logic      [23:0] vector_fetch_addr,
  output logic             pc_load,
  output logic      [23:0] pc_target,
  output logic      [3:0]  cpu_priority_level
);

  // ==========================================================================
  // Helpers
  function automatic logic in_vec(input logic [23:0] a);
    return (a >= VEC_FIRST) && (a <= VEC_LAST);
  endfunction

  function automatic logic [23:0] vec_addr(input logic [5:0] v, input logic alt);
    return (alt ? ALT_BASE : VEC_FIRST) + {17'h00000, v, 1'b0};
  endfunction

  // ==========================================================================
  // State
  logic [47:0] req_flags;
  logic [47:0] next_flags;
  logic [47:0] src_en;
  logic [2:0]  src_prio [48];
  logic [15:0] gctl1;
  logic [15:0] gctl2;
  logic [13:0] timed_low_priority_disable_count;
  logic [47:0] hw_set;
  logic [47:0] pend_q;
  logic [3:0]  trap_q;
  logic        eval_en;
  logic [4:0]  ext_s1;
  logic [4:0]  ext_s2;
  logic [4:0]  ext_s3;
  logic [4:0]  ext_level;
  logic        addr_err;
  logic [3:0]  trap_set;
  logic [3:0]  level_stack [STACK_DEPTH];
  logic [4:0]  depth;
  logic [2:0]  best_prio;
  logic [5:0]  best_src;
  logic [3:0]  trap_lvl;
  logic [5:0]  trap_vec;
  logic        take_trap;
  logic        take_irq;
  logic        nest_dis;
  logic        timed_low_priority_disable_active;
  logic [15:0] next_rdata;
  ctl_state_t  state;

  assign nest_dis    = gctl1[NEST_DIS_BIT];
  assign timed_low_priority_disable_active = timed_low_priority_disable_count != TIMED_LOW_PRIORITY_DISABLE_RST;

  // ==========================================================================
  // External pins: three flops, a change counts once two and three agree
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ext_s1    <= 5'h00;
      ext_s2    <= 5'h00;
      ext_s3    <= 5'h00;
      ext_level <= 5'h00;
    end else begin
      ext_s1 <= ext_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      for (int i = 0; i < NUM_EXT; i++) begin
        if (ext_s2[i] == ext_s3[i]) begin
          ext_level[i] <= ext_s3[i];
        end
      end
    end
  end

  // Polarity bit 0 takes rising edges, 1 falling edges
  always_comb begin
    hw_set = {3'h0, src_event};
    for (int i = 0; i < NUM_EXT; i++) begin
      if (ext_s2[i] == ext_s3[i] && ext_s3[i] != ext_level[i] && ext_s3[i] != gctl2[i]) begin
        hw_set[EXT_SRC[i]] = 1'b1;
      end
    end
    hw_set = hw_set & SRC_MASK;
  end

  // ==========================================================================
  // Request flags: set wins over a clearing write in the same cycle
  always_comb begin
    next_flags = req_flags;
    for (int k = 0; k < 3; k++) begin
      if (reg_wr && reg_addr == OFS_FLAGS + 5'(k)) begin
        next_flags[16*k +: 16] = reg_wdata;
      end
    end
    next_flags = (next_flags | hw_set) & SRC_MASK;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      req_flags <= {3{REG_RST}};
    end else begin
      req_flags <= next_flags;
    end
  end

  // ==========================================================================
  // Enables and priorities
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      src_en <= {3{REG_RST}};
      for (int i = 0; i < 48; i++) begin
        src_prio[i] <= REG_RST[2:0];
      end
    end else if (reg_wr) begin
      for (int k = 0; k < 3; k++) begin
        if (reg_addr == OFS_ENABLES + 5'(k)) begin
          src_en[16*k +: 16] <= reg_wdata & SRC_MASK[16*k +: 16];
        end
      end
      for (int j = 0; j < NUM_PRIO_REG; j++) begin
        if (reg_addr == OFS_PRIO + 5'(j)) begin
          for (int n = 0; n < 4; n++) begin
            src_prio[4*j+n] <= reg_wdata[4*n +: 3];
          end
        end
      end
    end
  end

  // ==========================================================================
  // Global controls, trap flags and timed disable
  assign addr_err = (fetch_valid && in_vec(fetch_addr))
                  || (jump_valid && in_vec(jump_target));

  always_comb begin
    trap_set = trap_event;
    trap_set[TRAP_ADDR] = trap_event[TRAP_ADDR] | addr_err;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      gctl1 <= REG_RST;
      gctl2 <= REG_RST;
    end else begin
      if (reg_wr && reg_addr == OFS_GCTL1) begin
        gctl1 <= (reg_wdata & GCTL1_WMASK) | {11'h000, trap_set, 1'b0};
      end else begin
        gctl1 <= gctl1 | {11'h000, trap_set, 1'b0};
      end
      if (reg_wr && reg_addr == OFS_GCTL2) begin
        gctl2 <= reg_wdata & GCTL2_WMASK;
      end
    end
  end

  // Writing the count stands in for the disable instruction
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      timed_low_priority_disable_count <= TIMED_LOW_PRIORITY_DISABLE_RST;
    end else if (reg_wr && reg_addr == OFS_TIMED_LOW_PRIORITY_DISABLE_COUNT) begin
      timed_low_priority_disable_count <= reg_wdata[13:0];
    end else if (instr_cycle && timed_low_priority_disable_active) begin
      timed_low_priority_disable_count <= timed_low_priority_disable_count - 14'h0001;
    end
  end

  // ==========================================================================
  // Sampling and arbitration
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pend_q  <= {3{REG_RST}};
      trap_q  <= 4'h0;
      eval_en <= 1'b0;
    end else begin
      eval_en <= instr_cycle;
      if (instr_cycle) begin
        pend_q <= req_flags & src_en;
        trap_q <= gctl1[TRAP_FLAG_LSB +: NUM_TRAP];
      end
    end
  end

  // Strict compare keeps the lowest number among equal priorities
  always_comb begin
    best_prio = 3'h0;
    best_src  = 6'h00;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (pend_q[i] && src_prio[i] > best_prio) begin
        best_prio = src_prio[i];
        best_src  = 6'(i);
      end
    end
    trap_lvl = 4'h0;
    trap_vec = 6'h00;
    for (int t = 0; t < NUM_TRAP; t++) begin
      if (trap_q[t] && TRAP_LEVEL[t] > trap_lvl) begin
        trap_lvl = TRAP_LEVEL[t];
        trap_vec = TRAP_VEC[t];
      end
    end
  end

  assign take_trap = trap_lvl > cpu_priority_level;
  assign take_irq  = best_prio != 3'h0
                   && {1'b0, best_prio} > cpu_priority_level
                   && !(nest_dis && depth != 5'h00)
                   && !(timed_low_priority_disable_active && best_prio <= TIMED_LOW_PRIORITY_DISABLE_FLOOR);

  // ==========================================================================
  // Offer, acknowledge, vector load
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state             <= ST_IDLE;
      irq_req           <= 1'b0;
      irq_level         <= LEVEL_RST;
      irq_vector_num    <= 6'h00;
      vector_fetch_addr <= 24'h000000;
      pc_load           <= 1'b0;
      pc_target         <= 24'h000000;
    end else begin
      pc_load <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (eval_en && (take_trap || take_irq)) begin
            state   <= ST_OFFER;
            irq_req <= 1'b1;
            if (take_trap) begin
              irq_level         <= trap_lvl;
              irq_vector_num    <= trap_vec;
              vector_fetch_addr <= vec_addr(trap_vec, gctl2[ALT_TABLE_BIT]);
            end else begin
              irq_level         <= {1'b0, best_prio};
              irq_vector_num    <= IRQ_VEC_BASE + best_src;
              vector_fetch_addr <= vec_addr(IRQ_VEC_BASE + best_src, gctl2[ALT_TABLE_BIT]);
            end
          end
        end
        ST_OFFER: begin
          if (irq_ack) begin
            irq_req <= 1'b0;
            state   <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (vector_word_valid) begin
            pc_load   <= 1'b1;
            pc_target <= vector_word;
            state     <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // CPU level and saved levels; a full stack drops the new save silently
  always_ff @(posedge sys_clk) begin
    if (state == ST_OFFER && irq_ack && depth != DEPTH_FULL) begin
      level_stack[depth[3:0]] <= cpu_priority_level;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cpu_priority_level <= LEVEL_RST;
      depth              <= 5'h00;
    end else if (state == ST_OFFER && irq_ack) begin
      cpu_priority_level <= irq_level;
      if (depth != DEPTH_FULL) begin
        depth <= depth + 5'h01;
      end
    end else if (irq_return && depth != 5'h00) begin
      cpu_priority_level <= level_stack[depth[3:0] - 4'h1];
      depth              <= depth - 5'h01;
    end else if (reg_wr && reg_addr == OFS_CPU_LEVEL && !nest_dis) begin
      cpu_priority_level <= reg_wdata[3:0];
    end
  end

  // ==========================================================================
  // Register reads
  always_comb begin
    next_rdata = REG_RST;
    for (int k = 0; k < 3; k++) begin
      if (reg_addr == OFS_FLAGS + 5'(k)) begin
        next_rdata = req_flags[16*k +: 16];
      end
      if (reg_addr == OFS_ENABLES + 5'(k)) begin
        next_rdata = src_en[16*k +: 16];
      end
    end
    for (int j = 0; j < NUM_PRIO_REG; j++) begin
      if (reg_addr == OFS_PRIO + 5'(j)) begin
        for (int n = 0; n < 4; n++) begin
          if (j < NUM_PRIO_REG - 1 || n < 2) begin
            next_rdata[4*n +: 4] = {1'b0, src_prio[4*j+n]};
          end
        end
      end
    end
    if (reg_addr == OFS_GCTL1) begin
      next_rdata = gctl1;
    end
    if (reg_addr == OFS_GCTL2) begin
      next_rdata = gctl2;
      next_rdata[TIMED_LOW_PRIORITY_DISABLE_BIT] = timed_low_priority_disable_active;
    end
    if (reg_addr == OFS_CPU_LEVEL) begin
      next_rdata = {12'h000, cpu_priority_level};
    end
    if (reg_addr == OFS_TIMED_LOW_PRIORITY_DISABLE_COUNT) begin
      next_rdata = {2'h0, timed_low_priority_disable_count};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      reg_rdata <= REG_RST;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : REG_RST;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence irq_offer_s;
    $rose(irq_req) && !irq_level[3];
  endsequence

  sequence trap_accept_s;
    state == ST_OFFER && irq_ack && irq_level[3];
  endsequence

  sequence vector_arrive_s;
    state == ST_FETCH && vector_word_valid;
  endsequence

  flag_set_wins_a: assert property (
    (|hw_set) |=> ((req_flags & $past(hw_set)) == $past(hw_set)))
    else $error("request flag lost an event");

  flag_hold_a: assert property (
    !reg_wr |=> ((~req_flags & $past(req_flags)) == 48'h0))
    else $error("request flag cleared without a write");

  offer_enabled_a: assert property (
    irq_offer_s |-> src_en[irq_vector_num - IRQ_VEC_BASE]
                    && src_prio[irq_vector_num - IRQ_VEC_BASE] != 3'h0)
    else $error("offered source disabled or at level zero");

  offer_above_level_a: assert property (
    $rose(irq_req) |-> irq_level > cpu_priority_level)
    else $error("offer not above cpu level");

  nest_block_a: assert property (
    (irq_offer_s and (nest_dis && depth != 5'h00)) |-> 1'b0)
    else $error("nested interrupt offered while nesting disabled");

  level_lock_a: assert property (
    (reg_wr && reg_addr == OFS_CPU_LEVEL && nest_dis && !irq_ack && !irq_return)
      |=> $stable(cpu_priority_level))
    else $error("cpu level written while locked");

  timed_low_priority_disable_block_a: assert property (
    (irq_offer_s and timed_low_priority_disable_active) |-> irq_level == 4'h7)
    else $error("low level offered during timed disable");

  trap_msb_a: assert property (
    trap_accept_s |=> cpu_priority_level[3])
    else $error("trap accepted without level top bit");

  addr_trap_a: assert property (
    addr_err |=> gctl1[TRAP_FLAG_LSB + TRAP_ADDR])
    else $error("vector space fetch raised no address trap");

  vector_load_a: assert property (
    vector_arrive_s |=> pc_load && pc_target == $past(vector_word) ##1 !pc_load)
    else $error("vector word not loaded for one cycle");

endmodule
`default_nettype wire

/* File: testbench/core_model.sv */
// Purpose: behavioural processor core that paces instruction cycles and takes offers
// Assumes: one offer at a time; the vector word is the vector address salted
// Notes:   the vector bus shows the inverse of its last word whenever it is idle
`timescale 1ns/1ps
`default_nettype none
module core_model #(
  parameter logic [23:0] WORD_SALT = 24'h5a5a00
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        irq_req,
  input  wire logic [23:0] vector_fetch_addr,
  input  wire logic [3:0]  ack_delay,
  output logic             instr_cycle,
  output logic             irq_ack,
  output logic             vector_word_valid,
  output logic      [23:0] vector_word
);
  // ==========================================================
  // Core sequencing
  logic [1:0]  phase;
  logic [1:0]  step;
  logic [3:0]  waited;
  logic [23:0] addr_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      phase             <= 2'h0;
      step              <= 2'h0;
      waited            <= 4'h0;
      addr_q            <= 24'h000000;
      instr_cycle       <= 1'b0;
      irq_ack           <= 1'b0;
      vector_word_valid <= 1'b0;
      vector_word       <= 24'h000000;
    end else begin
      phase             <= phase + 2'h1;
      instr_cycle       <= (phase == 2'h3);
      irq_ack           <= 1'b0;
      vector_word_valid <= 1'b0;
      // Idle bus must not look like a valid word
      vector_word       <= ~vector_word;
      case (step)
        2'h0: if (irq_req) begin
          if (waited == ack_delay) begin
            irq_ack <= 1'b1;
            addr_q  <= vector_fetch_addr;
            step    <= 2'h1;
            waited  <= 4'h0;
          end else begin
            waited <= waited + 4'h1;
          end
        end
        2'h1: step <= 2'h2;
        default: begin
          vector_word_valid <= 1'b1;
          vector_word       <= addr_q ^ WORD_SALT;
          step              <= 2'h0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: testbench/prioritized_interrupt_controller_tb.sv */
// Purpose: self-checking bench for the prioritized interrupt controller
// Assumes: core model acks offers after a programmable delay
// Notes:   expected vector words follow the salt that the core model applies
`timescale 1ns/1ps
`default_nettype none
module prioritized_interrupt_controller_tb
  import intc_pkg::*;
;
  localparam logic [23:0] SALT = 24'h5a5a00;
  // ==========================================================
  // Signals and instances
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [4:0]  reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [44:0] src_event = '0;
  logic [4:0]  ext_pin = 5'h00;
  logic [3:0]  trap_event = 4'h0;
  logic        fetch_valid = 1'b0;
  logic [23:0] fetch_addr = 24'h000000;
  logic        jump_valid = 1'b0;
  logic [23:0] jump_target = 24'h000000;
  logic        irq_return = 1'b0;
  logic [3:0]  ack_delay = 4'h0;
  logic [15:0] reg_rdata;
  logic        instr_cycle, irq_ack, vector_word_valid, irq_req, pc_load;
  logic [23:0] vector_word, vector_fetch_addr, pc_target;
  logic [3:0]  irq_level, cpu_priority_level;
  logic [5:0]  irq_vector_num;
  int          n_fail = 0;
  int          total_checks = 0;
  int          req_cnt = 0;
  int          cycles = 0;

  prio_intc DUT (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .src_event(src_event), .ext_pin(ext_pin), .trap_event(trap_event),
    .instr_cycle(instr_cycle), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .jump_valid(jump_valid), .jump_target(jump_target), .irq_ack(irq_ack),
    .irq_return(irq_return), .vector_word_valid(vector_word_valid),
    .vector_word(vector_word), .irq_req(irq_req), .irq_level(irq_level),
    .irq_vector_num(irq_vector_num), .vector_fetch_addr(vector_fetch_addr),
    .pc_load(pc_load), .pc_target(pc_target), .cpu_priority_level(cpu_priority_level));

  core_model #(.WORD_SALT(SALT)) core (.sys_clk(sys_clk), .reset_n(reset_n),
    .irq_req(irq_req), .vector_fetch_addr(vector_fetch_addr), .ack_delay(ack_delay),
    .instr_cycle(instr_cycle), .irq_ack(irq_ack), .vector_word_valid(vector_word_valid),
    .vector_word(vector_word));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (irq_req === 1'b1) req_cnt <= req_cnt + 1;
    if (cycles == 6000) begin
      n_fail = n_fail + 1;
      final_report();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic final_report();
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [4:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, {8'h00, reg_rdata}, {8'h00, e});
  endtask

  task automatic pulse(input logic [44:0] m);
    @(posedge sys_clk);
    src_event <= m;
    @(posedge sys_clk);
    src_event <= '0;
  endtask

  task automatic pc_ev(input logic jmp, input logic [23:0] a);
    @(posedge sys_clk);
    fetch_valid <= ~jmp;
    fetch_addr  <= a;
    jump_valid  <= jmp;
    jump_target <= a;
    @(posedge sys_clk);
    fetch_valid <= 1'b0;
    jump_valid  <= 1'b0;
  endtask

  task automatic ret();
    // Let one instruction cycle resample the cleared flags before the level drops
    tick(8);
    @(posedge sys_clk);
    irq_return <= 1'b1;
    @(posedge sys_clk);
    irq_return <= 1'b0;
  endtask

  task automatic quiet(input int n);
    int c;
    c = req_cnt;
    tick(n);
    chk("no offer", 24'(req_cnt - c), 24'h0);
  endtask

  task automatic service(input logic [3:0] lvl, input logic [5:0] vec);
    logic [23:0] a;
    int          i;
    a = VEC_FIRST + {17'h0, vec, 1'b0};
    i = 0;
    while (irq_req !== 1'b1 && i < 80) begin
      tick(1);
      i++;
    end
    chk("offer", {23'h0, irq_req}, 24'h1);
    chk("offer level", {20'h0, irq_level}, {20'h0, lvl});
    chk("vector num", {18'h0, irq_vector_num}, {18'h0, vec});
    chk("vector addr", vector_fetch_addr, a);
    i = 0;
    while (pc_load !== 1'b1 && i < 20) begin
      tick(1);
      i++;
    end
    chk("pc target", pc_target, a ^ SALT);
    chk("cpu level", {20'h0, cpu_priority_level}, {20'h0, lvl});
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk("level out", {20'h0, cpu_priority_level}, 24'h0);
    rdchk("flags0", OFS_FLAGS, 16'h0000);
    rdchk("enables0", OFS_ENABLES, 16'h0000);
    rdchk("level reg", OFS_CPU_LEVEL, 16'h0000);
    rdchk("unmapped", 5'h1f, 16'h0000);
  endtask

  task automatic t_flags();
    pulse(45'h000_0000_0008);
    rdchk("flag set", OFS_FLAGS, 16'h0008);
    quiet(24);
    @(posedge sys_clk);
    ext_pin <= 5'h01;
    tick(8);
    rdchk("ext flag", OFS_FLAGS, 16'h0009);
    wr(OFS_FLAGS, 16'h0000);
    rdchk("flag clear", OFS_FLAGS, 16'h0000);
    pulse(45'h200_0000_0000);
    rdchk("reserved flag", OFS_FLAGS + 5'h02, 16'h0000);
  endtask

  task automatic t_prio_fields();
    wr(OFS_PRIO, 16'hffff);
    rdchk("prio nibbles", OFS_PRIO, 16'h7777);
    wr(OFS_PRIO + 5'h0b, 16'hffff);
    rdchk("prio last", OFS_PRIO + 5'h0b, 16'h0077);
    wr(OFS_PRIO + 5'h0b, 16'h0000);
  endtask

  task automatic t_basic();
    wr(OFS_PRIO, 16'h0000);
    wr(OFS_ENABLES, 16'h0008);
    pulse(45'h000_0000_0008);
    quiet(24);
    wr(OFS_CPU_LEVEL, 16'h0003);
    wr(OFS_PRIO, 16'h3000);
    quiet(24);
    wr(OFS_CPU_LEVEL, 16'h0002);
    service(4'h3, 6'h0b);
    wr(OFS_FLAGS, 16'h0000);
    ret();
    tick(2);
    chk("level restored", {20'h0, cpu_priority_level}, 24'h2);
    wr(OFS_CPU_LEVEL, 16'h0000);
  endtask

  task automatic t_tie();
    ack_delay <= 4'h5;
    wr(OFS_ENABLES, 16'h0006);
    wr(OFS_PRIO, 16'h0550);
    pulse(45'h000_0000_0006);
    service(4'h5, 6'h09);
    wr(OFS_FLAGS, 16'h0000);
    ret();
  endtask

  task automatic t_nesting();
    wr(OFS_GCTL1, 16'h8000);
    wr(OFS_ENABLES, 16'h000a);
    wr(OFS_PRIO, 16'h3070);
    pulse(45'h000_0000_0008);
    service(4'h3, 6'h0b);
    pulse(45'h000_0000_0002);
    quiet(24);
    wr(OFS_CPU_LEVEL, 16'h0000);
    rdchk("level locked", OFS_CPU_LEVEL, 16'h0003);
    wr(OFS_GCTL1, 16'h0000);
    service(4'h7, 6'h09);
    wr(OFS_FLAGS, 16'h0000);
    ret();
    ret();
    tick(2);
    chk("level popped", {20'h0, cpu_priority_level}, 24'h0);
  endtask

  task automatic t_timed();
    wr(OFS_ENABLES, 16'h0008);
    wr(OFS_PRIO, 16'h6000);
    wr(OFS_TIMED_LOW_PRIORITY_DISABLE_COUNT, 16'h0008);
    rdchk("disable bit", OFS_GCTL2, 16'h4000);
    pulse(45'h000_0000_0008);
    quiet(16);
    service(4'h6, 6'h0b);
    rdchk("disable over", OFS_GCTL2, 16'h0000);
    wr(OFS_FLAGS, 16'h0000);
    ret();
  endtask

  task automatic t_traps();
    ack_delay <= 4'h6;
    wr(OFS_ENABLES, 16'h0000);
    pc_ev(1'b0, 24'h000100);
    rdchk("fetch ok", OFS_GCTL1, 16'h0000);
    pc_ev(1'b0, 24'h000010);
    rdchk("fetch trap", OFS_GCTL1, 16'h0004);
    service(4'hc, 6'h02);
    chk("level msb", {23'h0, cpu_priority_level[3]}, 24'h1);
    wr(OFS_GCTL1, 16'h0000);
    ret();
    wr(OFS_CPU_LEVEL, 16'h000f);
    pc_ev(1'b1, 24'h0000fe);
    rdchk("jump trap", OFS_GCTL1, 16'h0004);
    wr(OFS_GCTL1, 16'h0000);
    wr(OFS_CPU_LEVEL, 16'h0000);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    tick(1);
    t_reset();
    t_flags();
    t_prio_fields();
    t_basic();
    t_tie();
    t_nesting();
    t_timed();
    t_traps();
    final_report();
  end
endmodule
`default_nettype wire
